// ### pkg/fcr_params.svh
// Notes on behaviour
// (R01) tsd set: timestamp reads only at level 0
// (R02) de set: io breakpoints, dr4/dr5 fault
// (R03) de clear: dr4/dr5 alias dr6/dr7
// (R04) pse selects 4K or 4M pages
// (R05) pse ignored while pae set
// (R06) pae: wide entries, 4K or 2M pages
// (R07) mce: uncorrectable error raises machine check
// (R08) enabled errors logged regardless of mce
// (R09) pge: global entries survive base rewrite
// (R10) pce set: counter read any level
// (R11) legacy_simd_state_enable clear: simd instructions fault invalid
// (R12) simd_fp_fault_support clear: simd fp fault invalid
// (R13) user_descriptor_read_block: descriptor stores above level 0 fault
// (R14) five_level_translation_enable with long mode: five-level paging
// (R15) segment_base_access_enable gates segment base instructions
// (R16) context_tag_enable settable only in long mode
// (R17) extended_state_save_enable allows extended state instructions
// (R18) supervisor_fetch_block blocks supervisor fetch from user
// (R19) supervisor_data_block blocks supervisor data to user
// (R20) pke rising flushes whole tlb
// (R21) cet set with wp clear faults
// (R22) reserved control register numbers fault invalid
// (R23) reads return written bits, reserved zero
`ifndef FCR_PARAMS_SVH
`define FCR_PARAMS_SVH
`define FCR_BIT_TSD    2
`define FCR_BIT_DE     3
`define FCR_BIT_PSE    4
`define FCR_BIT_PAE    5
`define FCR_BIT_MCE    6
`define FCR_BIT_PGE    7
`define FCR_BIT_PCE    8
`define FCR_BIT_FXSR   9
`define FCR_BIT_XMMEX  10
`define FCR_BIT_USER_DESCRIPTOR_READ_BLOCK   11
`define FCR_BIT_FIVE_LEVEL_TRANSLATION_ENABLE   12
`define FCR_BIT_FSGS   16
`define FCR_BIT_PCID   17
`define FCR_BIT_XSAVE  18
`define FCR_BIT_SUPERVISOR_FETCH_BLOCK   20
`define FCR_BIT_SUPERVISOR_DATA_BLOCK   21
`define FCR_BIT_PKE    22
`define FCR_BIT_CET    23
`define FCR_RESET      64'h0000_0000_0000_0000
`define FCR_IMPL_MASK  64'h0000_0000_00F7_1FFF
`define FCR_NUM_FEAT   4'h4
`define FCR_NUM_TPR    4'h8
`define FCR_PAGE_4K    2'h0
`define FCR_PAGE_4M    2'h1
`define FCR_PAGE_2M    2'h2
`endif

// ### pkg/fcr_pkg.sv
package fcr_pkg;
   // access kinds checked by the gate
   typedef enum logic [3:0] {
      FCR_OP_NONE  = 4'h0,
      FCR_OP_TSC   = 4'h1,
      FCR_OP_PMC   = 4'h2,
      FCR_OP_DR45  = 4'h3,
      FCR_OP_SIMD  = 4'h4,
      FCR_OP_SIMDX = 4'h5,
      FCR_OP_DESC  = 4'h6,
      FCR_OP_SEGB  = 4'h7,
      FCR_OP_XCR   = 4'h8,
      FCR_OP_PKR   = 4'h9,
      FCR_OP_INVPC = 4'hA
   } fcr_op_t;
   // fault answers
   typedef enum logic [1:0] {
      FCR_FLT_NONE = 2'h0,
      FCR_FLT_UD   = 2'h1,
      FCR_FLT_GP   = 2'h2
   } fcr_fault_t;
endpackage : fcr_pkg

// ### hw/fcr_cr_decode.sv
`timescale 1ns/1ns
`include "fcr_params.svh"
// control register number decode
module fcr_cr_decode
   import fcr_pkg::*;
#(
   parameter logic [15:0] IMPL_MASK = 16'h011D
) (
   // request
   input  wire logic [3:0] crNum,
   input  wire logic       mode64,
   // answer
   output logic            crBad
);
   // ==========================================
   // decode
   // cr8 only reachable in 64-bit mode; others by mask
   always_comb begin
      if (crNum == `FCR_NUM_TPR)
         crBad = !mode64;            // R22
      else
         crBad = !IMPL_MASK[crNum];  // R22
   end
endmodule : fcr_cr_decode

// ### hw/fcr_page_cfg.sv
`timescale 1ns/1ns
`include "fcr_params.svh"
// paging configuration derived from feature bits
module fcr_page_cfg
   import fcr_pkg::*;
(
   // feature bits
   input  wire logic       large_page_size_enable,
   input  wire logic       wide_physical_address_enable,
   input  wire logic       five_level_translation_enable,
   input  wire logic       longMode,
   input  wire logic       largePageFlag,
   // derived
   output logic [1:0]      pageSize,
   output logic            wideEntry,
   output logic            fiveLevel
);
   // ==========================================
   // page size
   always_comb begin
      wideEntry = wide_physical_address_enable;                       // R06
      fiveLevel = five_level_translation_enable && longMode;          // R14
      if (wide_physical_address_enable)                               // R05
         pageSize = largePageFlag ? `FCR_PAGE_2M : `FCR_PAGE_4K; // R06
      else if (large_page_size_enable)
         pageSize = largePageFlag ? `FCR_PAGE_4M : `FCR_PAGE_4K; // R04
      else
         pageSize = `FCR_PAGE_4K;            // R04
   end
endmodule : fcr_page_cfg

// ### hw/fcr_top.sv
`timescale 1ns/1ns
`include "fcr_params.svh"
// feature control register with privilege and fault gating
module fcr_top
   import fcr_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // register move port
   input  wire logic        crWrite,
   input  wire logic        crRead,
   input  wire logic [3:0]  crNum,
   input  wire logic [63:0] crWdata,
   output logic [63:0]      crRdata,
   output logic             crRvalid,
   // core state
   input  wire logic        longModeActive,
   input  wire logic        mode64,
   input  wire logic        writeProtect,
   input  wire logic [1:0]  cpl,
   input  wire logic        largePageFlag,
   // instruction check port
   input  wire logic        opValid,
   input  wire fcr_op_t     opKind,
   input  wire logic [2:0]  drNum,
   input  wire logic        fpUnmasked,
   output fcr_fault_t       opFault,
   output logic [2:0]       drMapped,
   output logic             opDone,
   // hardware error port
   input  wire logic        hwErr,
   input  wire logic        hwErrUncorr,
   input  wire logic        bankReportEn,
   output logic             machineCheck,
   output logic             errLogged,
   // tlb and feature outputs
   input  wire logic        baseRewrite,
   output logic             tlbFlushAll,
   output logic             tlbFlushNonGlobal,
   output logic [63:0]      featureBits,
   output logic [1:0]       pageSizeSel,
   output logic             wideEntries,
   output logic             fiveLevelPaging,
   output logic             ioBreakEnable,
   output logic             retCheckEnable
);
   // ==========================================
   // state
   logic [63:0] fcr;           // register contents
   logic [63:0] next_fcr;      // candidate after write
   logic        crBad;         // register number faults
   logic [1:0]  pageSize;      // derived page size
   logic        wideEntry;     // derived wide entries
   logic        fiveLevel;     // derived paging depth
   logic        wrFault;       // write refused
   logic        feat;          // access targets this register

   // ==========================================
   // helpers
   // a field lookup used by many checks
   function automatic logic fbit(input logic [63:0] v, input int n);
      return v[n];
   endfunction : fbit

   fcr_cr_decode u_dec (
      .crNum  (crNum),
      .mode64 (mode64),
      .crBad  (crBad)
   );

   fcr_page_cfg u_pg (
      .large_page_size_enable           (fbit(fcr, `FCR_BIT_PSE)),
      .wide_physical_address_enable           (fbit(fcr, `FCR_BIT_PAE)),
      .five_level_translation_enable          (fbit(fcr, `FCR_BIT_FIVE_LEVEL_TRANSLATION_ENABLE)),
      .longMode      (longModeActive),
      .largePageFlag (largePageFlag),
      .pageSize      (pageSize),
      .wideEntry     (wideEntry),
      .fiveLevel     (fiveLevel)
   );

   // ==========================================
   // write path
   // reserved bits dropped so reads return zero there
   assign feat     = (crNum == `FCR_NUM_FEAT);
   assign next_fcr = crWdata & `FCR_IMPL_MASK;                      // R23
   // refusal checked against the new value, no partial update
   assign wrFault  = (fbit(next_fcr, `FCR_BIT_PCID) && !longModeActive)   // R16
                  || (fbit(next_fcr, `FCR_BIT_CET) && !writeProtect);     // R21

   // register update
   always_ff @(posedge ref_clk) begin
      if (srst)
         fcr <= `FCR_RESET;
      else if (crWrite && feat && !crBad && !wrFault)
         fcr <= next_fcr;                                           // R23
   end

   // read answer, one cycle late
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         crRdata  <= 64'h0;
         crRvalid <= 1'b0;
      end else begin
         crRvalid <= crRead && feat;
         crRdata  <= (crRead && feat) ? fcr : 64'h0;                // R23
      end
   end

   // tlb maintenance
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tlbFlushAll       <= 1'b0;
         tlbFlushNonGlobal <= 1'b0;
      end else begin
         // pke rising edge empties everything
         tlbFlushAll <= crWrite && feat && !crBad && !wrFault
                     && fbit(next_fcr, `FCR_BIT_PKE) && !fbit(fcr, `FCR_BIT_PKE); // R20
         // base rewrite keeps global entries only when pge set
         tlbFlushNonGlobal <= baseRewrite && fbit(fcr, `FCR_BIT_PGE);  // R09
      end
   end

   // ==========================================
   // instruction gate
   // faults: ud before gp, register moves checked here too
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         opFault  <= FCR_FLT_NONE;
         drMapped <= 3'h0;
         opDone   <= 1'b0;
      end else begin
         opDone   <= opValid || (crWrite || crRead);
         drMapped <= drNum;
         opFault  <= FCR_FLT_NONE;
         if (crWrite || crRead) begin
            if (crBad)
               opFault <= FCR_FLT_UD;                              // R22
            else if (crWrite && feat && wrFault)
               opFault <= FCR_FLT_GP;                              // R16 R21
         end else if (opValid) begin
            unique case (opKind)
               FCR_OP_TSC:
                  if (fbit(fcr, `FCR_BIT_TSD) && cpl != 2'h0)
                     opFault <= FCR_FLT_GP;                        // R01
               FCR_OP_PMC:
                  if (!fbit(fcr, `FCR_BIT_PCE) && cpl != 2'h0)
                     opFault <= FCR_FLT_GP;                        // R10
               FCR_OP_DR45: begin
                  if (fbit(fcr, `FCR_BIT_DE))
                     opFault <= FCR_FLT_UD;                        // R02
                  else if (drNum == 3'h4 || drNum == 3'h5)
                     drMapped <= drNum + 3'h2;                     // R03
               end
               FCR_OP_SIMD:
                  if (!fbit(fcr, `FCR_BIT_FXSR))
                     opFault <= FCR_FLT_UD;                        // R11
               FCR_OP_SIMDX:
                  if (!fbit(fcr, `FCR_BIT_FXSR) ||
                      (fpUnmasked && !fbit(fcr, `FCR_BIT_XMMEX)))
                     opFault <= FCR_FLT_UD;                        // R11 R12
               FCR_OP_DESC:
                  if (fbit(fcr, `FCR_BIT_USER_DESCRIPTOR_READ_BLOCK) && cpl != 2'h0)
                     opFault <= FCR_FLT_GP;                        // R13
               FCR_OP_SEGB:
                  if (!fbit(fcr, `FCR_BIT_FSGS) || !mode64)
                     opFault <= FCR_FLT_UD;                        // R15
               FCR_OP_XCR:
                  if (!fbit(fcr, `FCR_BIT_XSAVE))
                     opFault <= FCR_FLT_UD;                        // R17
               FCR_OP_PKR:
                  if (!fbit(fcr, `FCR_BIT_PKE))
                     opFault <= FCR_FLT_UD;                        // R20
               FCR_OP_INVPC:
                  if (!fbit(fcr, `FCR_BIT_PCID))
                     opFault <= FCR_FLT_UD;                        // R16
               default:
                  opFault <= FCR_FLT_NONE;
            endcase
         end
      end
   end

   // ==========================================
   // hardware errors
   // logging never depends on the trap bit
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         machineCheck <= 1'b0;
         errLogged    <= 1'b0;
      end else begin
         errLogged    <= hwErr && bankReportEn;                      // R08
         machineCheck <= hwErr && bankReportEn && hwErrUncorr
                      && fbit(fcr, `FCR_BIT_MCE);                    // R07
      end
   end

   // ==========================================
   // feature outputs, registered
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         featureBits     <= 64'h0;
         pageSizeSel     <= `FCR_PAGE_4K;
         wideEntries     <= 1'b0;
         fiveLevelPaging <= 1'b0;
         ioBreakEnable   <= 1'b0;
         retCheckEnable  <= 1'b0;
      end else begin
         // supervisor_fetch_block and supervisor_data_block travel to the page checker here
         featureBits     <= fcr;                                     // R18 R19
         pageSizeSel     <= pageSize;                                // R04 R05 R06
         wideEntries     <= wideEntry;                               // R06
         fiveLevelPaging <= fiveLevel;                               // R14
         ioBreakEnable   <= fbit(fcr, `FCR_BIT_DE);                  // R02 R03
         retCheckEnable  <= fbit(fcr, `FCR_BIT_CET);                 // R21
      end
   end

   // ==========================================
   // checks
   AST_TSD_FAULT: assert property (@(posedge ref_clk) disable iff (srst) // R01
      opValid && opKind == FCR_OP_TSC && fcr[`FCR_BIT_TSD] && cpl != 2'h0 && !crWrite && !crRead
      |=> opFault == FCR_FLT_GP) else $error("tsd fault missing");
   AST_PMC_OPEN: assert property (@(posedge ref_clk) disable iff (srst) // R10
      opValid && opKind == FCR_OP_PMC && fcr[`FCR_BIT_PCE] && !crWrite && !crRead
      |=> opFault == FCR_FLT_NONE) else $error("pmc wrongly refused");
   AST_DR_ALIAS: assert property (@(posedge ref_clk) disable iff (srst) // R03
      opValid && opKind == FCR_OP_DR45 && !fcr[`FCR_BIT_DE] && drNum == 3'h4 && !crWrite && !crRead
      |=> drMapped == 3'h6) else $error("dr4 not aliased");
   AST_PSE_IGNORED: assert property (@(posedge ref_clk) disable iff (srst) // R05
      fcr[`FCR_BIT_PAE] && largePageFlag |=> pageSizeSel == `FCR_PAGE_2M)
      else $error("pse not ignored");
   AST_MC_TRAP: assert property (@(posedge ref_clk) disable iff (srst) // R07
      hwErr && bankReportEn && !hwErrUncorr |=> !machineCheck) else $error("correctable trapped");
   AST_LOG: assert property (@(posedge ref_clk) disable iff (srst) // R08
      hwErr && bankReportEn |=> errLogged) else $error("error not logged");
   AST_PKE_FLUSH: assert property (@(posedge ref_clk) disable iff (srst) // R20
      $rose(fcr[`FCR_BIT_PKE]) |-> tlbFlushAll)
      else $error("pke flush missing");
   AST_CET_WP: assert property (@(posedge ref_clk) disable iff (srst) // R21
      crWrite && feat && crWdata[`FCR_BIT_CET] && !writeProtect
      |=> opFault == FCR_FLT_GP && $stable(fcr)) else $error("cet without wp");
   AST_PCID_LM: assert property (@(posedge ref_clk) disable iff (srst) // R16
      $rose(fcr[`FCR_BIT_PCID]) |-> $past(longModeActive)) else $error("context_tag_enable set outside long mode");
   AST_CR_UD: assert property (@(posedge ref_clk) disable iff (srst) // R22
      (crRead || crWrite) && (crNum == 4'h1 || crNum == 4'h5) |=> opFault == FCR_FLT_UD)
      else $error("reserved cr not faulted");
   AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (srst) // R23
      crRvalid |-> (crRdata & ~`FCR_IMPL_MASK) == 64'h0) else $error("reserved bits set");

   // ==========================================
   // gate sequences
   // a gate request of one kind that no register move pre-empts
   sequence s_gate(fcr_op_t k);
      opValid && opKind == k && !crWrite && !crRead;
   endsequence
   // a write the register takes, refused ones excluded
   sequence s_fcr_write;
      crWrite && feat && !crBad && !wrFault;
   endsequence

   // gate answers, one cycle after the request
   AST_DR_FAULT: assert property (@(posedge ref_clk) disable iff (srst) // R02
      s_gate(FCR_OP_DR45) ##0 fcr[`FCR_BIT_DE] |=> opFault == FCR_FLT_UD)
      else $error("reserved debug register not refused");
   AST_DR5_ALIAS: assert property (@(posedge ref_clk) disable iff (srst) // R03
      s_gate(FCR_OP_DR45) ##0 !fcr[`FCR_BIT_DE] && drNum == 3'h5 |=> drMapped == 3'h7)
      else $error("dr5 not aliased");
   AST_SIMD_UD: assert property (@(posedge ref_clk) disable iff (srst) // R11
      s_gate(FCR_OP_SIMD) ##0 !fcr[`FCR_BIT_FXSR] |=> opFault == FCR_FLT_UD)
      else $error("simd allowed without state support");
   AST_XMM_UD: assert property (@(posedge ref_clk) disable iff (srst) // R12
      s_gate(FCR_OP_SIMDX) ##0 fpUnmasked && !fcr[`FCR_BIT_XMMEX] |=> opFault == FCR_FLT_UD)
      else $error("unmasked simd fp fault not invalid");
   AST_DESC_GP: assert property (@(posedge ref_clk) disable iff (srst) // R13
      s_gate(FCR_OP_DESC) ##0 fcr[`FCR_BIT_USER_DESCRIPTOR_READ_BLOCK] && cpl != 2'h0 |=> opFault == FCR_FLT_GP)
      else $error("descriptor store allowed above level 0");
   AST_SEGB_UD: assert property (@(posedge ref_clk) disable iff (srst) // R15
      s_gate(FCR_OP_SEGB) ##0 (!fcr[`FCR_BIT_FSGS] || !mode64) |=> opFault == FCR_FLT_UD)
      else $error("segment base access not refused");
   AST_INVPC_UD: assert property (@(posedge ref_clk) disable iff (srst) // R16
      s_gate(FCR_OP_INVPC) ##0 !fcr[`FCR_BIT_PCID] |=> opFault == FCR_FLT_UD)
      else $error("context invalidate without context tags");
   AST_XCR_UD: assert property (@(posedge ref_clk) disable iff (srst) // R17
      s_gate(FCR_OP_XCR) ##0 !fcr[`FCR_BIT_XSAVE] |=> opFault == FCR_FLT_UD)
      else $error("extended control access not refused");
   AST_PKR_UD: assert property (@(posedge ref_clk) disable iff (srst) // R20
      s_gate(FCR_OP_PKR) ##0 !fcr[`FCR_BIT_PKE] |=> opFault == FCR_FLT_UD)
      else $error("key register access without keys");
   AST_CR8_OK: assert property (@(posedge ref_clk) disable iff (srst) // R22
      (crRead || crWrite) && crNum == `FCR_NUM_TPR && mode64 |=> opFault != FCR_FLT_UD)
      else $error("cr8 refused in 64-bit mode");

   // paging and tlb copies
   AST_PAGE_4K: assert property (@(posedge ref_clk) disable iff (srst) // R04
      !fcr[`FCR_BIT_PAE] && !fcr[`FCR_BIT_PSE] |=> pageSizeSel == `FCR_PAGE_4K)
      else $error("large page without size extension");
   AST_FIVE_LEVEL: assert property (@(posedge ref_clk) disable iff (srst) // R14
      fcr[`FCR_BIT_FIVE_LEVEL_TRANSLATION_ENABLE] && longModeActive |=> fiveLevelPaging)
      else $error("five-level paging not enabled");
   AST_NONGLOBAL: assert property (@(posedge ref_clk) disable iff (srst) // R09
      baseRewrite |=> tlbFlushNonGlobal == $past(fcr[`FCR_BIT_PGE]))
      else $error("global entries not kept on rewrite");
   // a flush without a rising key bit would cost a full tlb refill
   AST_PKE_ONLY: assert property (@(posedge ref_clk) disable iff (srst) // R20
      tlbFlushAll |-> $rose(fcr[`FCR_BIT_PKE]))
      else $error("spurious full tlb flush");
   AST_FEAT_COPY: assert property (@(posedge ref_clk) disable iff (srst) // R18 R19
      s_fcr_write |=> ##1 featureBits == ($past(crWdata, 2) & `FCR_IMPL_MASK))
      else $error("feature copy lost a write");
endmodule : fcr_top

// ### bench/fcr_top_bench.sv
`timescale 1ns/1ns
// ==========================================
// feature control register bench
module fcr_top_bench
   import fcr_pkg::*;
;
   // compare helper, counts every sample
   `define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin nFail++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
   // clock and reset
   logic ref_clk, srst;
   // register move port
   logic crWrite, crRead, crRvalid;
   logic [3:0] crNum;
   logic [63:0] crWdata, crRdata, featureBits;
   // core state
   logic longModeActive, mode64, writeProtect, largePageFlag;
   logic [1:0] cpl, pageSizeSel;
   // instruction check port
   logic opValid, fpUnmasked, opDone;
   fcr_op_t opKind;
   logic [2:0] drNum, drMapped;
   fcr_fault_t opFault;
   // errors, tlb, features
   logic hwErr, hwErrUncorr, bankReportEn, machineCheck, errLogged, baseRewrite;
   logic tlbFlushAll, tlbFlushNonGlobal, wideEntries, fiveLevelPaging;
   logic ioBreakEnable, retCheckEnable;
   // verdict counters
   int nFail, samplesChecked;
   localparam logic [63:0] IMPL = 64'h0000_0000_00F7_1FFF;
   fcr_top dut (.ref_clk(ref_clk), .srst(srst), .crWrite(crWrite), .crRead(crRead),
      .crNum(crNum), .crWdata(crWdata), .crRdata(crRdata), .crRvalid(crRvalid),
      .longModeActive(longModeActive), .mode64(mode64), .writeProtect(writeProtect),
      .cpl(cpl), .largePageFlag(largePageFlag), .opValid(opValid), .opKind(opKind),
      .drNum(drNum), .fpUnmasked(fpUnmasked), .opFault(opFault), .drMapped(drMapped),
      .opDone(opDone), .hwErr(hwErr), .hwErrUncorr(hwErrUncorr),
      .bankReportEn(bankReportEn), .machineCheck(machineCheck), .errLogged(errLogged),
      .baseRewrite(baseRewrite), .tlbFlushAll(tlbFlushAll),
      .tlbFlushNonGlobal(tlbFlushNonGlobal), .featureBits(featureBits),
      .pageSizeSel(pageSizeSel), .wideEntries(wideEntries),
      .fiveLevelPaging(fiveLevelPaging), .ioBreakEnable(ioBreakEnable),
      .retCheckEnable(retCheckEnable));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ==========================================
   // access tasks, one request cycle each
   task automatic finishTest;
      if (nFail == 0 && samplesChecked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finishTest
   // write, then wait one more cycle so the feature copies settle
   task automatic wr(input logic [3:0] n, input logic [63:0] d, input fcr_fault_t f,
                     input logic fl);
      @(posedge ref_clk); #1 crWrite = 1'b1; crNum = n; crWdata = d;
      @(posedge ref_clk); #1 crWrite = 1'b0;
      `CHK(opFault, f)
      `CHK(tlbFlushAll, fl)
      @(posedge ref_clk); #1;
   endtask : wr
   task automatic rd(input logic [3:0] n, input logic [63:0] d);
      @(posedge ref_clk); #1 crRead = 1'b1; crNum = n;
      @(posedge ref_clk); #1 crRead = 1'b0;
      `CHK(crRvalid, 1'b1)
      `CHK(crRdata, d)
   endtask : rd
   // drMapped only means something for debug register accesses
   task automatic op(input fcr_op_t k, input logic [2:0] dn, input fcr_fault_t f,
                     input logic [2:0] dm);
      @(posedge ref_clk); #1 opValid = 1'b1; opKind = k; drNum = dn;
      @(posedge ref_clk); #1 opValid = 1'b0;
      `CHK(opDone, 1'b1)
      `CHK(opFault, f)
      if (k == FCR_OP_DR45) `CHK(drMapped, dm)
   endtask : op
   task automatic hw(input logic u, input logic en, input logic mc, input logic lg);
      @(posedge ref_clk); #1 hwErr = 1'b1; hwErrUncorr = u; bankReportEn = en;
      @(posedge ref_clk); #1 hwErr = 1'b0;
      `CHK(machineCheck, mc)
      `CHK(errLogged, lg)
   endtask : hw
   task automatic rewrite(input logic e);
      @(posedge ref_clk); #1 baseRewrite = 1'b1;
      @(posedge ref_clk); #1 baseRewrite = 1'b0;
      `CHK(tlbFlushNonGlobal, e)
   endtask : rewrite
   // two settle cycles covers either a registered or direct path
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : settle
   // ==========================================
   // watchdog, a hang counts as a mismatch
   initial begin
      #200000 nFail++;
      finishTest();
   end
   // ==========================================
   // main sequence
   initial begin
      {crWrite, crRead, opValid, hwErr, hwErrUncorr, bankReportEn, baseRewrite} = '0;
      {longModeActive, mode64, writeProtect, largePageFlag, fpUnmasked} = '0;
      crNum = 4'h0; crWdata = 64'h0; cpl = 2'h0; drNum = 3'h0; opKind = FCR_OP_NONE;
      nFail = 0; samplesChecked = 0; srst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 srst = 1'b0;
      `CHK(featureBits, 64'h0)
      rd(4'h4, 64'h0);
      longModeActive = 1'b1; mode64 = 1'b1; writeProtect = 1'b1;
      wr(4'h4, '1, FCR_FLT_NONE, 1'b1);
      rd(4'h4, IMPL);
      `CHK({retCheckEnable, ioBreakEnable, fiveLevelPaging, wideEntries}, 4'hF)
      `CHK(featureBits, IMPL)
      wr(4'h4, '1, FCR_FLT_NONE, 1'b0);
      longModeActive = 1'b0;
      wr(4'h4, 64'h0000_0000_0002_0000, FCR_FLT_GP, 1'b0);
      longModeActive = 1'b1; writeProtect = 1'b0;
      wr(4'h4, 64'h0000_0000_0080_0000, FCR_FLT_GP, 1'b0);
      writeProtect = 1'b1;
      rd(4'h4, IMPL);
      // reserved numbers, and number 8 outside 64-bit mode
      for (int m = 0; m < 2; m++) begin
         mode64 = m[0];
         for (int n = 0; n < 16; n++) begin
            if (n != 4) wr(n[3:0], 64'h0, (n == 1 || (n >= 5 && n <= 7) || n >= 9 ||
               (n == 8 && m == 0)) ? FCR_FLT_UD : FCR_FLT_NONE, 1'b0);
         end
      end
      // every feature on, user level
      cpl = 2'h3; fpUnmasked = 1'b1;
      op(FCR_OP_TSC, 3'h0, FCR_FLT_GP, 3'h0);
      op(FCR_OP_PMC, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_DR45, 3'h4, FCR_FLT_UD, 3'h4);
      op(FCR_OP_DESC, 3'h0, FCR_FLT_GP, 3'h0);
      op(FCR_OP_SIMDX, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_SEGB, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_XCR, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_PKR, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_INVPC, 3'h0, FCR_FLT_NONE, 3'h0);
      cpl = 2'h0;
      op(FCR_OP_TSC, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_DESC, 3'h0, FCR_FLT_NONE, 3'h0);
      // every feature off, user level
      wr(4'h4, 64'h0, FCR_FLT_NONE, 1'b0);
      cpl = 2'h3;
      `CHK({retCheckEnable, ioBreakEnable}, 2'h0)
      op(FCR_OP_TSC, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_PMC, 3'h0, FCR_FLT_GP, 3'h0);
      op(FCR_OP_DR45, 3'h4, FCR_FLT_NONE, 3'h6);
      op(FCR_OP_DR45, 3'h5, FCR_FLT_NONE, 3'h7);
      op(FCR_OP_DR45, 3'h2, FCR_FLT_NONE, 3'h2);
      op(FCR_OP_SIMD, 3'h0, FCR_FLT_UD, 3'h0);
      op(FCR_OP_DESC, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_SEGB, 3'h0, FCR_FLT_UD, 3'h0);
      op(FCR_OP_XCR, 3'h0, FCR_FLT_UD, 3'h0);
      op(FCR_OP_PKR, 3'h0, FCR_FLT_UD, 3'h0);
      op(FCR_OP_INVPC, 3'h0, FCR_FLT_UD, 3'h0);
      wr(4'h4, 64'h0000_0000_0000_0200, FCR_FLT_NONE, 1'b0);
      op(FCR_OP_SIMD, 3'h0, FCR_FLT_NONE, 3'h0);
      op(FCR_OP_SIMDX, 3'h0, FCR_FLT_UD, 3'h0);
      fpUnmasked = 1'b0;
      op(FCR_OP_SIMDX, 3'h0, FCR_FLT_NONE, 3'h0);
      wr(4'h4, 64'h0000_0000_0001_0000, FCR_FLT_NONE, 1'b0);
      mode64 = 1'b0;
      op(FCR_OP_SEGB, 3'h0, FCR_FLT_UD, 3'h0);
      // page size selection
      wr(4'h4, 64'h0000_0000_0000_0010, FCR_FLT_NONE, 1'b0);
      largePageFlag = 1'b1;
      settle();
      `CHK(pageSizeSel, 2'h1)
      largePageFlag = 1'b0;
      settle();
      `CHK(pageSizeSel, 2'h0)
      largePageFlag = 1'b1;
      wr(4'h4, 64'h0000_0000_0000_0030, FCR_FLT_NONE, 1'b0);
      `CHK({pageSizeSel, wideEntries}, 3'h5)
      wr(4'h4, 64'h0000_0000_0000_1000, FCR_FLT_NONE, 1'b0);
      `CHK(fiveLevelPaging, 1'b1)
      longModeActive = 1'b0;
      settle();
      `CHK(fiveLevelPaging, 1'b0)
      // hardware errors with and without the trap bit
      wr(4'h4, 64'h0000_0000_0000_0040, FCR_FLT_NONE, 1'b0);
      hw(1'b1, 1'b1, 1'b1, 1'b1);
      hw(1'b0, 1'b1, 1'b0, 1'b1);
      hw(1'b1, 1'b0, 1'b0, 1'b0);
      wr(4'h4, 64'h0, FCR_FLT_NONE, 1'b0);
      hw(1'b1, 1'b1, 1'b0, 1'b1);
      // base rewrite keeps global entries only with the global bit
      rewrite(1'b0);
      wr(4'h4, 64'h0000_0000_0000_0080, FCR_FLT_NONE, 1'b0);
      rewrite(1'b1);
      finishTest();
   end
endmodule : fcr_top_bench
